// ### design/cdt_pkg.sv
// Package: register map, field layout, reset values and shared types for the codec clock tree
// ----------------------------------------------------------------------------
// Summary of operation
// - Root clock chosen from master, bit clock, first general pin or PLL input.
// - DAC modulator clock is root over pre times modulator divider; rate adds oversampling.
// - ADC modulator clock is root over pre times modulator divider; rate adds oversampling.
// - Channel dividers are seven bits; DAC ratio ten bits split; ADC ratio eight bits.
// - DAC power-down runs an internal shutdown; host keeps both DAC dividers enabled.
// - Two DAC status flags at bits seven and three; then modulator, then pre-divider off.
// - With ADC dividers disabled, the ADC path is clocked from the DAC dividers.
// - ADC power-down runs an internal shutdown; host keeps both ADC dividers enabled.
// - ADC status flag at bit six; then modulator, then pre-divider may be disabled.
// - With drive bit three set, bit clock pin outputs its input divided by 2..128; at ratio one it stays high.
// - Two-bit mux picks bit-clock divider input among DAC/ADC DSP and modulator clocks.
// - General clock goes out on a chosen pin, its input divided by 2..128; at ratio one it stays high.
// - Three-bit mux picks the general clock divider input.
// ----------------------------------------------------------------------------
package cdt_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_ROOT_SEL = 8'h04;
  localparam logic [7:0] ADDR_DAC_PRE = 8'h0b;
  localparam logic [7:0] ADDR_DAC_MOD = 8'h0c;
  localparam logic [7:0] ADDR_DAC_OVERSAMPLING_RATIO_HI = 8'h0d;
  localparam logic [7:0] ADDR_DAC_OVERSAMPLING_RATIO_LO = 8'h0e;
  localparam logic [7:0] ADDR_ADC_PRE = 8'h12;
  localparam logic [7:0] ADDR_ADC_MOD = 8'h13;
  localparam logic [7:0] ADDR_ADC_OVERSAMPLING_RATIO = 8'h14;
  localparam logic [7:0] ADDR_GEN_SEL = 8'h19;
  localparam logic [7:0] ADDR_GEN_DIV = 8'h1a;
  localparam logic [7:0] ADDR_AIF_CTRL = 8'h1b;
  localparam logic [7:0] ADDR_BCLK_SEL = 8'h1d;
  localparam logic [7:0] ADDR_BCLK_DIV = 8'h1e;
  localparam logic [7:0] ADDR_ADC_STATUS = 8'h24;
  localparam logic [7:0] ADDR_DAC_STATUS = 8'h25;
  // Field positions
  localparam int DIV_EN_BIT = 7;
  localparam int BCLK_DRIVE_BIT = 3;
  localparam int DAC_FLAG_A_BIT = 7;
  localparam int DAC_FLAG_B_BIT = 3;
  localparam int ADC_FLAG_BIT = 6;
  localparam int DIV7_W = 7;
  localparam int DAC_OVERSAMPLING_RATIO_W = 10;
  localparam int ADC_OVERSAMPLING_RATIO_W = 8;
  // Reset values: dividers disabled at divide-by-one, ratios at 128
  localparam logic [7:0] DIV_RST = 8'h01;
  localparam logic [1:0] DAC_OVERSAMPLING_RATIO_HI_RST = 2'h0;
  localparam logic [7:0] OSR_LO_RST = 8'h80;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // Divider slots in the tree
  localparam int NDIV = 8;
  localparam int D_DAC_PRE_DIVIDER = 0;
  localparam int D_DAC_MODULATOR_DIVIDER = 1;
  localparam int D_DAC_OVERSAMPLING_RATIO = 2;
  localparam int D_ADC_PRE_DIVIDER = 3;
  localparam int D_ADC_MODULATOR_DIVIDER = 4;
  localparam int D_ADC_OVERSAMPLING_RATIO = 5;
  localparam int D_BDIV = 6;
  localparam int D_GDIV = 7;
  // Shutdown sequence states, Gray along off, on, shutting down
  typedef enum logic [1:0] {
    CDT_OFF = 2'b00,
    CDT_ON = 2'b01,
    CDT_SHUT = 2'b11
  } cdt_chan_type;
endpackage

// ### design/cdt_clock_tree.sv
// Module: codec clock source mux, divider tree, channel shutdown and clock pin outputs
`timescale 1ns/1ps
`default_nettype none
module cdt_clock_tree #(
  parameter int CNT_W = 11,
  parameter int SHUT_TICKS = 16
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  input wire logic i_mclk_tick,
  input wire logic i_bclk_tick,
  input wire logic i_first_general_pin_tick,
  input wire logic i_pll_tick,
  input wire logic i_dac_power_up,
  input wire logic i_adc_power_up,
  input wire logic [1:0] i_gclk_pin_sel,
  output logic o_root_tick,
  output logic o_dac_dsp_tick,
  output logic o_dac_mod_tick,
  output logic o_dac_fs_tick,
  output logic o_adc_dsp_tick,
  output logic o_adc_mod_tick,
  output logic o_adc_fs_tick,
  output logic o_bclk_o,
  output logic o_bclk_oe,
  output logic [3:0] o_gclk_o,
  output logic [3:0] o_gclk_oe
);
  import cdt_pkg::*;

  typedef struct packed {
    logic [1:0] root_sel;
    logic [7:0] dac_pre_divider;
    logic [7:0] dac_modulator_divider;
    logic [1:0] dac_oversampling_ratio_hi;
    logic [7:0] dac_oversampling_ratio_lo;
    logic [7:0] adc_pre_divider;
    logic [7:0] adc_modulator_divider;
    logic [7:0] adc_oversampling_ratio;
    logic [2:0] gen_sel;
    logic [7:0] gen_div;
    logic [7:0] aif;
    logic [1:0] bclk_sel;
    logic [7:0] bclk_div;
    logic [7:0] rdata;
    logic root;
    logic adc_dsp;
    logic adc_mod;
    logic [NDIV-1:0] act_en;
    logic [NDIV-1:0] out;
    logic [NDIV-1:0][CNT_W-1:0] cnt;
    logic [NDIV-1:0][CNT_W-1:0] lim;
    cdt_chan_type [1:0] chan;
    logic [1:0][CNT_W-1:0] shut_cnt;
    logic bclk;
    logic gclk;
  } cdt_state_type;

  cdt_state_type state_reg;
  cdt_state_type state_next;
  logic [NDIV-1:0][CNT_W-1:0] req_lim;
  logic [NDIV-1:0] req_en;
  logic [NDIV-1:0] src_tick;
  logic [1:0] chan_req;
  logic [1:0] chan_tick;
  logic [NDIV-1:0] wrap;

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // Zero in a divider field selects the largest ratio the field allows
  function automatic logic [CNT_W-1:0] field_lim(input logic [DAC_OVERSAMPLING_RATIO_W-1:0] v, input int w);
    logic [CNT_W-1:0] r;
    r = CNT_W'(v);
    if (v == '0) begin
      r = CNT_W'(1) << w;
    end
    return r;
  endfunction

  function automatic logic [CNT_W-1:0] half_of(input logic [CNT_W-1:0] l);
    return CNT_W'((l + CNT_W'(1)) >> 1);
  endfunction

  // ----------------------------------------------------------------------------
  // Divider requests and tree wiring
  // ----------------------------------------------------------------------------
  always_comb begin
    req_lim[D_DAC_PRE_DIVIDER] = field_lim(DAC_OVERSAMPLING_RATIO_W'(state_reg.dac_pre_divider[DIV7_W-1:0]), DIV7_W);
    req_lim[D_DAC_MODULATOR_DIVIDER] = field_lim(DAC_OVERSAMPLING_RATIO_W'(state_reg.dac_modulator_divider[DIV7_W-1:0]), DIV7_W);
    req_lim[D_DAC_OVERSAMPLING_RATIO] = field_lim({state_reg.dac_oversampling_ratio_hi, state_reg.dac_oversampling_ratio_lo}, DAC_OVERSAMPLING_RATIO_W);
    req_lim[D_ADC_PRE_DIVIDER] = field_lim(DAC_OVERSAMPLING_RATIO_W'(state_reg.adc_pre_divider[DIV7_W-1:0]), DIV7_W);
    req_lim[D_ADC_MODULATOR_DIVIDER] = field_lim(DAC_OVERSAMPLING_RATIO_W'(state_reg.adc_modulator_divider[DIV7_W-1:0]), DIV7_W);
    req_lim[D_ADC_OVERSAMPLING_RATIO] = field_lim(DAC_OVERSAMPLING_RATIO_W'(state_reg.adc_oversampling_ratio), ADC_OVERSAMPLING_RATIO_W);
    req_lim[D_BDIV] = field_lim(DAC_OVERSAMPLING_RATIO_W'(state_reg.bclk_div[DIV7_W-1:0]), DIV7_W);
    req_lim[D_GDIV] = field_lim(DAC_OVERSAMPLING_RATIO_W'(state_reg.gen_div[DIV7_W-1:0]), DIV7_W);
    req_en[D_DAC_PRE_DIVIDER] = state_reg.dac_pre_divider[DIV_EN_BIT];
    req_en[D_DAC_MODULATOR_DIVIDER] = state_reg.dac_modulator_divider[DIV_EN_BIT];
    req_en[D_DAC_OVERSAMPLING_RATIO] = 1'b1;
    req_en[D_ADC_PRE_DIVIDER] = state_reg.adc_pre_divider[DIV_EN_BIT];
    req_en[D_ADC_MODULATOR_DIVIDER] = state_reg.adc_modulator_divider[DIV_EN_BIT];
    req_en[D_ADC_OVERSAMPLING_RATIO] = 1'b1;
    req_en[D_BDIV] = state_reg.bclk_div[DIV_EN_BIT] & state_reg.aif[BCLK_DRIVE_BIT];
    req_en[D_GDIV] = state_reg.gen_div[DIV_EN_BIT];
    // Cascade: each stage counts ticks of its parent
    src_tick[D_DAC_PRE_DIVIDER] = state_reg.root;
    src_tick[D_DAC_MODULATOR_DIVIDER] = state_reg.out[D_DAC_PRE_DIVIDER];
    src_tick[D_DAC_OVERSAMPLING_RATIO] = state_reg.out[D_DAC_MODULATOR_DIVIDER];
    src_tick[D_ADC_PRE_DIVIDER] = state_reg.root;
    src_tick[D_ADC_MODULATOR_DIVIDER] = state_reg.out[D_ADC_PRE_DIVIDER];
    src_tick[D_ADC_OVERSAMPLING_RATIO] = state_reg.adc_mod;
    case (state_reg.bclk_sel)
      2'h0: src_tick[D_BDIV] = state_reg.out[D_DAC_PRE_DIVIDER];
      2'h1: src_tick[D_BDIV] = state_reg.out[D_DAC_MODULATOR_DIVIDER];
      2'h2: src_tick[D_BDIV] = state_reg.adc_dsp;
      default: src_tick[D_BDIV] = state_reg.adc_mod;
    endcase
    case (state_reg.gen_sel)
      3'h0: src_tick[D_GDIV] = state_reg.root;
      3'h1: src_tick[D_GDIV] = state_reg.out[D_DAC_PRE_DIVIDER];
      3'h2: src_tick[D_GDIV] = state_reg.out[D_DAC_MODULATOR_DIVIDER];
      3'h3: src_tick[D_GDIV] = state_reg.adc_dsp;
      3'h4: src_tick[D_GDIV] = state_reg.adc_mod;
      3'h5: src_tick[D_GDIV] = state_reg.out[D_DAC_OVERSAMPLING_RATIO];
      3'h6: src_tick[D_GDIV] = state_reg.out[D_ADC_OVERSAMPLING_RATIO];
      default: src_tick[D_GDIV] = 1'b0;
    endcase
    chan_req = {i_adc_power_up, i_dac_power_up};
    chan_tick = {state_reg.adc_mod, state_reg.out[D_DAC_MODULATOR_DIVIDER]};
    // A divider wraps on the parent tick that completes its current ratio
    for (int i = 0; i < NDIV; i++) begin
      wrap[i] = src_tick[i] && state_reg.act_en[i] &&
                (state_reg.cnt[i] == state_reg.lim[i] - CNT_W'(1));
    end
  end

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.out = '0;
    // Register writes
    if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_ROOT_SEL: state_next.root_sel = i_reg_wdata[1:0];
        ADDR_DAC_PRE: state_next.dac_pre_divider = i_reg_wdata;
        ADDR_DAC_MOD: state_next.dac_modulator_divider = i_reg_wdata;
        ADDR_DAC_OVERSAMPLING_RATIO_HI: state_next.dac_oversampling_ratio_hi = i_reg_wdata[1:0];
        ADDR_DAC_OVERSAMPLING_RATIO_LO: state_next.dac_oversampling_ratio_lo = i_reg_wdata;
        ADDR_ADC_PRE: state_next.adc_pre_divider = i_reg_wdata;
        ADDR_ADC_MOD: state_next.adc_modulator_divider = i_reg_wdata;
        ADDR_ADC_OVERSAMPLING_RATIO: state_next.adc_oversampling_ratio = i_reg_wdata;
        ADDR_GEN_SEL: state_next.gen_sel = i_reg_wdata[2:0];
        ADDR_GEN_DIV: state_next.gen_div = i_reg_wdata;
        ADDR_AIF_CTRL: state_next.aif = i_reg_wdata;
        ADDR_BCLK_SEL: state_next.bclk_sel = i_reg_wdata[1:0];
        ADDR_BCLK_DIV: state_next.bclk_div = i_reg_wdata;
        default: state_next.root_sel = state_reg.root_sel;
      endcase
    end
    // Register reads, captured so the data port comes from a flop
    if (i_reg_rd) begin
      state_next.rdata = '0;
      case (i_reg_addr)
        ADDR_ROOT_SEL: state_next.rdata = {6'h00, state_reg.root_sel};
        ADDR_DAC_PRE: state_next.rdata = state_reg.dac_pre_divider;
        ADDR_DAC_MOD: state_next.rdata = state_reg.dac_modulator_divider;
        ADDR_DAC_OVERSAMPLING_RATIO_HI: state_next.rdata = {6'h00, state_reg.dac_oversampling_ratio_hi};
        ADDR_DAC_OVERSAMPLING_RATIO_LO: state_next.rdata = state_reg.dac_oversampling_ratio_lo;
        ADDR_ADC_PRE: state_next.rdata = state_reg.adc_pre_divider;
        ADDR_ADC_MOD: state_next.rdata = state_reg.adc_modulator_divider;
        ADDR_ADC_OVERSAMPLING_RATIO: state_next.rdata = state_reg.adc_oversampling_ratio;
        ADDR_GEN_SEL: state_next.rdata = {5'h00, state_reg.gen_sel};
        ADDR_GEN_DIV: state_next.rdata = state_reg.gen_div;
        ADDR_AIF_CTRL: state_next.rdata = state_reg.aif;
        ADDR_BCLK_SEL: state_next.rdata = {6'h00, state_reg.bclk_sel};
        ADDR_BCLK_DIV: state_next.rdata = state_reg.bclk_div;
        ADDR_ADC_STATUS: state_next.rdata[ADC_FLAG_BIT] = (state_reg.chan[1] != CDT_OFF);
        ADDR_DAC_STATUS: begin
          state_next.rdata[DAC_FLAG_A_BIT] = (state_reg.chan[0] != CDT_OFF);
          state_next.rdata[DAC_FLAG_B_BIT] = (state_reg.chan[0] != CDT_OFF);
        end
        default: state_next.rdata = '0;
      endcase
    end
    // Root source mux
    case (state_reg.root_sel)
      2'h0: state_next.root = i_mclk_tick;
      2'h1: state_next.root = i_bclk_tick;
      2'h2: state_next.root = i_first_general_pin_tick;
      default: state_next.root = i_pll_tick;
    endcase
    // Dividers. An idle divider starts cleanly at count zero; a running one
    // only reloads its ratio and enable when it wraps, so no period is cut short.
    for (int i = 0; i < NDIV; i++) begin
      if (!state_reg.act_en[i]) begin
        state_next.cnt[i] = '0;
        if (req_en[i]) begin
          state_next.act_en[i] = 1'b1;
          state_next.lim[i] = req_lim[i];
        end
      end else if (src_tick[i]) begin
        if (state_reg.cnt[i] == state_reg.lim[i] - CNT_W'(1)) begin
          state_next.cnt[i] = '0;
          state_next.out[i] = 1'b1;
          state_next.lim[i] = req_lim[i];
          state_next.act_en[i] = req_en[i];
        end else begin
          state_next.cnt[i] = state_reg.cnt[i] + CNT_W'(1);
        end
      end
    end
    // ADC path falls back to the DAC dividers while its own are off
    state_next.adc_dsp = state_reg.act_en[D_ADC_PRE_DIVIDER] ? state_next.out[D_ADC_PRE_DIVIDER] : state_next.out[D_DAC_PRE_DIVIDER];
    state_next.adc_mod = state_reg.act_en[D_ADC_MODULATOR_DIVIDER] ? state_next.out[D_ADC_MODULATOR_DIVIDER] : state_next.out[D_DAC_MODULATOR_DIVIDER];
    // Pin levels: high for the first half of each divided period. A ratio of one
    // cannot make a square wave from single ticks, so the level then stays high.
    state_next.bclk = state_next.act_en[D_BDIV] &&
                      (state_next.cnt[D_BDIV] < half_of(state_next.lim[D_BDIV]));
    state_next.gclk = state_next.act_en[D_GDIV] &&
                      (state_next.cnt[D_GDIV] < half_of(state_next.lim[D_GDIV]));
    // Channel shutdown: the flag stays up until enough modulator ticks have
    // passed, so the sequence stalls if the channel's modulator tick stops early (ADC falls back to the DAC modulator tick).
    for (int c = 0; c < 2; c++) begin
      case (state_reg.chan[c])
        CDT_OFF: begin
          if (chan_req[c]) begin
            state_next.chan[c] = CDT_ON;
          end
        end
        CDT_ON: begin
          if (!chan_req[c]) begin
            state_next.chan[c] = CDT_SHUT;
            state_next.shut_cnt[c] = '0;
          end
        end
        CDT_SHUT: begin
          if (chan_req[c]) begin
            state_next.chan[c] = CDT_ON;
          end else if (chan_tick[c]) begin
            if (state_reg.shut_cnt[c] == CNT_W'(SHUT_TICKS - 1)) begin
              state_next.chan[c] = CDT_OFF;
            end else begin
              state_next.shut_cnt[c] = state_reg.shut_cnt[c] + CNT_W'(1);
            end
          end
        end
        default: state_next.chan[c] = CDT_OFF;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= '0;
      state_reg.dac_pre_divider <= DIV_RST;
      state_reg.dac_modulator_divider <= DIV_RST;
      state_reg.dac_oversampling_ratio_hi <= DAC_OVERSAMPLING_RATIO_HI_RST;
      state_reg.dac_oversampling_ratio_lo <= OSR_LO_RST;
      state_reg.adc_pre_divider <= DIV_RST;
      state_reg.adc_modulator_divider <= DIV_RST;
      state_reg.adc_oversampling_ratio <= OSR_LO_RST;
      state_reg.gen_div <= DIV_RST;
      state_reg.bclk_div <= DIV_RST;
      state_reg.aif <= CTRL_RST;
      state_reg.chan <= '{CDT_OFF, CDT_OFF};
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign o_reg_rdata = state_reg.rdata;
  assign o_root_tick = state_reg.root;
  assign o_dac_dsp_tick = state_reg.out[D_DAC_PRE_DIVIDER];
  assign o_dac_mod_tick = state_reg.out[D_DAC_MODULATOR_DIVIDER];
  assign o_dac_fs_tick = state_reg.out[D_DAC_OVERSAMPLING_RATIO];
  assign o_adc_dsp_tick = state_reg.adc_dsp;
  assign o_adc_mod_tick = state_reg.adc_mod;
  assign o_adc_fs_tick = state_reg.out[D_ADC_OVERSAMPLING_RATIO];
  assign o_bclk_o = state_reg.bclk;
  assign o_bclk_oe = state_reg.act_en[D_BDIV];
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      o_gclk_oe[k] = state_reg.act_en[D_GDIV] && (i_gclk_pin_sel == 2'(k));
      o_gclk_o[k] = o_gclk_oe[k] && state_reg.gclk;
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cdt_cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);

  AST_ROOT_MUX: assert property ((state_reg.root_sel == 2'h3) |=> (o_root_tick == $past(i_pll_tick)))
    else $error("root tick does not follow the PLL input");
  AST_DAC_MOD_CHAIN: assert property (o_dac_mod_tick |-> $past(o_dac_dsp_tick))
    else $error("DAC modulator tick without a pre-divider tick");
  AST_DAC_FS_CHAIN: assert property (o_dac_fs_tick |-> $past(o_dac_mod_tick))
    else $error("DAC rate tick without a modulator tick");
  AST_ADC_FS_CHAIN: assert property (o_adc_fs_tick |-> $past(o_adc_mod_tick))
    else $error("ADC rate tick without a modulator tick");
  AST_ADC_FALLBACK: assert property (!state_reg.act_en[D_ADC_MODULATOR_DIVIDER] |=>
    (o_adc_mod_tick == $past(state_next.out[D_DAC_MODULATOR_DIVIDER])))
    else $error("ADC modulator tick not taken from the DAC path");
  AST_ZERO_IS_128: assert property ((!state_reg.act_en[D_DAC_PRE_DIVIDER] && state_reg.dac_pre_divider == 8'h80) |=>
    (state_reg.lim[D_DAC_PRE_DIVIDER] == CNT_W'(128)))
    else $error("zero divider value is not divide-by-128");
  // Ratio and enable of a running divider may only move at its wrap
  AST_MID_PERIOD_STABLE: assert property ((state_reg.act_en[D_DAC_MODULATOR_DIVIDER] && !wrap[D_DAC_MODULATOR_DIVIDER]) |=>
    ($stable(state_reg.lim[D_DAC_MODULATOR_DIVIDER]) && state_reg.act_en[D_DAC_MODULATOR_DIVIDER]))
    else $error("divider changed inside a period");
  AST_DAC_SHUTDOWN: assert property ((state_reg.chan[0] == CDT_ON && !i_dac_power_up) |=>
    (state_reg.chan[0] == CDT_SHUT))
    else $error("DAC power-down did not start the shutdown sequence");
  AST_ADC_SHUTDOWN: assert property ((state_reg.chan[1] == CDT_ON && !i_adc_power_up) |=>
    (state_reg.chan[1] == CDT_SHUT))
    else $error("ADC power-down did not start the shutdown sequence");
  AST_SHUT_NEEDS_TICKS: assert property ((state_reg.chan[1] == CDT_SHUT && !o_adc_mod_tick) |=>
    (state_reg.chan[1] != CDT_OFF))
    else $error("ADC reported down without a modulator tick");
  AST_DAC_STATUS_READ: assert property ((i_reg_rd && i_reg_addr == ADDR_DAC_STATUS) |=>
    ((o_reg_rdata[DAC_FLAG_A_BIT] == o_reg_rdata[DAC_FLAG_B_BIT]) &&
     (o_reg_rdata[DAC_FLAG_A_BIT] == ($past(state_reg.chan[0]) != CDT_OFF))))
    else $error("DAC status read does not show the channel state");
  AST_ADC_STATUS_READ: assert property ((i_reg_rd && i_reg_addr == ADDR_ADC_STATUS) |=>
    (o_reg_rdata == (8'(($past(state_reg.chan[1]) != CDT_OFF)) << ADC_FLAG_BIT)))
    else $error("ADC status read does not show the channel state");
  // The drive bit gates only the start; a stop waits for the wrap
  AST_BCLK_DRIVE: assert property ($rose(o_bclk_oe) |-> $past(state_reg.aif[BCLK_DRIVE_BIT]))
    else $error("bit clock driven without the drive bit");
  AST_BCLK_IDLE_LOW: assert property (!o_bclk_oe |-> !o_bclk_o)
    else $error("bit clock level high while the pin is released");
  AST_GCLK_ONE_PIN: assert property ($onehot0(o_gclk_oe))
    else $error("general clock enabled on more than one pin");

  COV_DAC_DOWN: cover property ((state_reg.chan[0] == CDT_SHUT) ##1 (state_reg.chan[0] == CDT_OFF));
  COV_ADC_DOWN: cover property ((state_reg.chan[1] == CDT_SHUT) ##1 (state_reg.chan[1] == CDT_OFF));
  COV_BCLK_RISE: cover property (o_bclk_oe && $rose(o_bclk_o));
  COV_ADC_FALLBACK_FS: cover property (!state_reg.act_en[D_ADC_MODULATOR_DIVIDER] && o_adc_fs_tick);
  COV_GCLK_TICK: cover property (state_reg.out[D_GDIV]);
endmodule // cdt_clock_tree
`default_nettype wire

// ### verification/cdt_src_model.sv
// Source clock model: reference tick trains for the four root clock inputs
`timescale 1ns/1ps
`default_nettype none
module cdt_src_model #(
  parameter int P_MCLK = 2,
  parameter int P_BCLK = 3,
  parameter int P_GPIO = 5,
  parameter int P_PLL = 7
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_pll_on,
  output logic o_mclk_tick,
  output logic o_bclk_tick,
  output logic o_first_general_pin_tick,
  output logic o_pll_tick
);
  int phase;
  // Wraps at 210 so every period must divide it; other periods would jitter
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      phase <= 0;
    end else begin
      phase <= (phase + 1) % 210;
    end
  end
  assign o_mclk_tick = i_nrst && (phase % P_MCLK) == 0;
  assign o_bclk_tick = i_nrst && (phase % P_BCLK) == 0;
  assign o_first_general_pin_tick = i_nrst && (phase % P_GPIO) == 0;
  // No output until the host has powered the loop up
  assign o_pll_tick = i_nrst && i_pll_on && (phase % P_PLL) == 0;
endmodule // cdt_src_model
`default_nettype wire

// ### verification/cdt_clock_tree_tb_top.sv
// Testbench: register access and clock-count checks for the codec clock tree
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module cdt_clock_tree_tb_top;
  import cdt_pkg::*;
  logic clk, nrst, wr, rd, dpu, apu, pll_on, mt, bt, gt, pt;
  logic root, dd, dm, df, ad, am, af, bo, boe;
  logic [7:0] addr, wdata, rdata, d;
  logic [1:0] psel;
  logic [3:0] go, goe;
  int failures = 0;
  int samples_checked = 0;
  int cnt[9];
  logic [7:0] ra[16] = '{8'h04, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h12, 8'h13, 8'h14,
                         8'h19, 8'h1a, 8'h1b, 8'h1d, 8'h1e, 8'h24, 8'h25, 8'h30};
  logic [7:0] rv[16] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h80, 8'h01, 8'h01, 8'h80,
                         8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
  int per[4] = '{2, 3, 5, 7};
  int bexp[4] = '{60, 20, 24, 24};
  int gexp[8] = '{120, 60, 20, 24, 24, 5, 6, 0};

  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  cdt_src_model #(.P_MCLK(2), .P_BCLK(3), .P_GPIO(5), .P_PLL(7)) u_cdt_src_model (.i_core_clk(clk),
    .i_nrst(nrst), .i_pll_on(pll_on), .o_mclk_tick(mt), .o_bclk_tick(bt), .o_first_general_pin_tick(gt), .o_pll_tick(pt));

  cdt_clock_tree #(.SHUT_TICKS(2)) u_cdt_clock_tree (.i_core_clk(clk), .i_nrst(nrst), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_mclk_tick(mt),
    .i_bclk_tick(bt), .i_first_general_pin_tick(gt), .i_pll_tick(pt), .i_dac_power_up(dpu), .i_adc_power_up(apu),
    .i_gclk_pin_sel(psel), .o_root_tick(root), .o_dac_dsp_tick(dd), .o_dac_mod_tick(dm),
    .o_dac_fs_tick(df), .o_adc_dsp_tick(ad), .o_adc_mod_tick(am), .o_adc_fs_tick(af),
    .o_bclk_o(bo), .o_bclk_oe(boe), .o_gclk_o(go), .o_gclk_oe(goe));

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #2;
    addr = a;
    wdata = v;
    wr = 1;
    @(posedge clk);
    #2;
    wr = 0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    #2;
    addr = a;
    rd = 1;
    @(posedge clk);
    #2;
    rd = 0;
    @(posedge clk);
    #2;
    v = rdata;
  endtask

  // Settle, then count rising edges; n must be a multiple of every period seen
  task automatic meas(input int n);
    logic [8:0] pv, lv;
    repeat (300) @(negedge clk);
    foreach (cnt[i]) cnt[i] = 0;
    pv = {go[psel], bo, af, am, ad, df, dm, dd, root};
    repeat (n) begin
      @(negedge clk);
      lv = {go[psel], bo, af, am, ad, df, dm, dd, root};
      for (int i = 0; i < 9; i++) cnt[i] += int'(lv[i] & ~pv[i]);
      pv = lv;
    end
  endtask

  task automatic exp_ticks(input int e[7]);
    for (int i = 0; i < 7; i++) `CHK(cnt[i], e[i])
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    failures++;
    stop_test();
  end

  initial begin
    {nrst, wr, rd, dpu, apu, pll_on, addr, wdata, psel} = '0;
    repeat (3) @(posedge clk);
    #2;
    nrst = 1;
    foreach (ra[i]) begin
      rd_reg(ra[i], d);
      `CHK(d, rv[i])
    end
    wr_reg(8'h25, 8'hff);
    wr_reg(8'h30, 8'h5a);
    wr_reg(8'h04, 8'hff);
    wr_reg(8'h0d, 8'hff);
    rd_reg(8'h25, d);
    `CHK(d, 8'h00)
    rd_reg(8'h30, d);
    `CHK(d, 8'h00)
    rd_reg(8'h04, d);
    `CHK(d, 8'h03)
    rd_reg(8'h0d, d);
    `CHK(d, 8'h03)
    $display("register map done");
    pll_on = 1;
    for (int s = 0; s < 4; s++) begin
      wr_reg(8'h04, 8'(s));
      meas(210);
      `CHK(cnt[0], 210 / per[s])
    end
    $display("root select done");
    wr_reg(8'h04, 8'h00);
    wr_reg(8'h0b, 8'h82);
    wr_reg(8'h0c, 8'h83);
    wr_reg(8'h0d, 8'h00);
    wr_reg(8'h0e, 8'h04);
    wr_reg(8'h14, 8'h04);
    // Oversampling dividers run from reset at ratio 128 and take the new ratio only at
    // their first wrap, 128 modulator ticks of 12 cycles after the modulator starts
    repeat (1400) @(posedge clk);
    meas(480);
    exp_ticks('{240, 120, 40, 10, 120, 40, 10});
    wr_reg(8'h12, 8'h85);
    wr_reg(8'h13, 8'h81);
    meas(480);
    exp_ticks('{240, 120, 40, 10, 48, 48, 12});
    wr_reg(8'h0b, 8'h80);
    meas(1536);
    `CHK(cnt[1], 6)
    `CHK(cnt[2], 2)
    wr_reg(8'h0b, 8'h82);
    $display("divider chain done");
    wr_reg(8'h1e, 8'h82);
    wr_reg(8'h1b, 8'h08);
    for (int m = 0; m < 4; m++) begin
      wr_reg(8'h1d, 8'(m));
      meas(480);
      `CHK(cnt[7], bexp[m])
      `CHK(boe, 1'b1)
    end
    wr_reg(8'h1b, 8'h00);
    meas(24);
    `CHK(boe, 1'b0)
    $display("bit clock done");
    wr_reg(8'h1a, 8'h82);
    for (int g = 0; g < 8; g++) begin
      wr_reg(8'h19, 8'(g));
      psel = 2'(g);
      meas(480);
      `CHK(cnt[8], gexp[g])
      if (g < 7) `CHK(goe, 4'h1 << psel)
    end
    $display("general clock done");
    @(posedge clk);
    #2;
    apu = 1;
    rd_reg(8'h24, d);
    `CHK(d, 8'h40)
    apu = 0;
    rd_reg(8'h24, d);
    `CHK(d, 8'h40)
    repeat (200) @(posedge clk);
    rd_reg(8'h24, d);
    `CHK(d, 8'h00)
    dpu = 1;
    rd_reg(8'h25, d);
    `CHK(d, 8'h88)
    dpu = 0;
    rd_reg(8'h25, d);
    `CHK(d, 8'h88)
    repeat (200) @(posedge clk);
    rd_reg(8'h25, d);
    `CHK(d, 8'h00)
    wr_reg(8'h0c, 8'h03);
    // Let the modulator divider reach its wrap and stop before its parent goes
    repeat (24) @(posedge clk);
    wr_reg(8'h0b, 8'h02);
    meas(120);
    `CHK(cnt[2], 0)
    `CHK(cnt[1], 0)
    wr_reg(8'h0b, 8'h80);
    meas(1536);
    `CHK(cnt[1], 6)
    $display("power down done");
    stop_test();
  end
endmodule // cdt_clock_tree_tb_top
`default_nettype wire
